// ---- verilog/pms_regs.v ----
`timescale 1ns/100ps
`include "pms_consts.vh"

module pms_regs
#(
  // identifier words: arbitrary neutral values
  parameter [15:0] PHY_ID_HI       = 16'h1234,
  parameter [15:0] PHY_ID_LO       = 16'h5678,
  // set when the line side supports only one duplex mode
  parameter        SINGLE_DUPLEX   = 1'b0,
  parameter        SINGLE_DUP_FULL = 1'b1,
  // duplex used while looped back, whatever the control bit says
  parameter        LOOPBACK_FULL   = 1'b1
)
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire [4:0]  i_reg_addr,
  input  wire        i_reg_wr,
  input  wire [15:0] i_reg_wdata,
  input  wire        i_reg_rd,
  output wire [15:0] o_reg_rdata,
  output wire        o_reg_rvalid,
  input  wire        i_an_restart_ack,
  input  wire        i_an_complete,
  input  wire        i_an_speed_100,
  input  wire        i_an_full_duplex,
  input  wire        i_link_ok,
  input  wire        i_jabber,
  input  wire        i_tx_en,
  input  wire        i_line_col,
  output wire        o_an_enable,
  output wire        o_an_restart,
  output wire [15:0] o_adv_word,
  output wire        o_speed_100,
  output wire        o_full_duplex,
  output wire        o_loopback,
  output wire        o_rx_isolate,
  output wire        o_power_down,
  output wire        o_col
);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function hit;
    input [4:0] addr;
    input [4:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire wr_ctrl   = i_reg_wr & hit(i_reg_addr, `PMS_OFF_CTRL);
  wire wr_adv    = i_reg_wr & hit(i_reg_addr, `PMS_OFF_ADV);
  wire rd_status = i_reg_rd & hit(i_reg_addr, `PMS_OFF_STATUS);

  // --------------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------------
  reg       loopback_q;
  reg       speed_q;
  reg       an_en_q;
  reg       pwr_down_q;
  reg       rsvd10_q;
  reg       restart_q;
  reg       duplex_q;
  reg       col_test_q;
  reg [6:0] ctrl_rsvd_q;

  reg       restart_d;

  // restart stays pending until the negotiation engine takes it
  always @*
  begin
    restart_d = restart_q;
    if (restart_q && i_an_restart_ack)
      restart_d = 1'b0;
    if (wr_ctrl && i_reg_wdata[`PMS_CTRL_AN_RESTART])
      restart_d = 1'b1;
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      loopback_q  <= 1'b0;
      speed_q     <= `PMS_CTRL_SPEED_RST;
      an_en_q     <= `PMS_CTRL_AN_EN_RST;
      pwr_down_q  <= 1'b0;
      rsvd10_q    <= 1'b0;
      restart_q   <= 1'b0;
      duplex_q    <= 1'b0;
      col_test_q  <= 1'b0;
      ctrl_rsvd_q <= `PMS_CTRL_RSVD_RST;
    end
    else
    begin
      restart_q <= restart_d;
      if (wr_ctrl)
      begin
        loopback_q  <= i_reg_wdata[`PMS_CTRL_LOOPBACK];
        speed_q     <= i_reg_wdata[`PMS_CTRL_SPEED];
        an_en_q     <= i_reg_wdata[`PMS_CTRL_AN_EN];
        pwr_down_q  <= i_reg_wdata[`PMS_CTRL_PWR_DOWN];
        rsvd10_q    <= i_reg_wdata[`PMS_CTRL_RSVD10];
        duplex_q    <= i_reg_wdata[`PMS_CTRL_DUPLEX];
        col_test_q  <= i_reg_wdata[`PMS_CTRL_COL_TEST];
        // kept as written; software is expected to write zeros here
        ctrl_rsvd_q <= i_reg_wdata[`PMS_CTRL_RSVD_HI:`PMS_CTRL_RSVD_LO];
      end
    end
  end

  // a single-mode PHY shows its only mode instead of the stored bit
  wire duplex_view = SINGLE_DUPLEX ? SINGLE_DUP_FULL : duplex_q;

  wire [15:0] ctrl_word;
  assign ctrl_word = {1'b0, loopback_q, speed_q, an_en_q, pwr_down_q, rsvd10_q,
                      restart_q, duplex_view, col_test_q, ctrl_rsvd_q};

  // --------------------------------------------------------------------------
  // negotiation complete flag
  // --------------------------------------------------------------------------
  reg an_done_q;

  // a fresh restart wins over a completion seen in the same cycle, since
  // that completion belongs to the negotiation being abandoned
  always @(posedge i_clk)
  begin
    if (i_rst)
      an_done_q <= 1'b0;
    else if (wr_ctrl && i_reg_wdata[`PMS_CTRL_AN_RESTART])
      an_done_q <= 1'b0;
    else if (restart_q)
      an_done_q <= 1'b0;
    else if (i_an_complete)
      an_done_q <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // latched link and jabber indications
  // --------------------------------------------------------------------------
  wire link_view;
  wire jabber_view;

  pms_latch_bit
  #(
    .EVENT_LEVEL (1'b0),
    .RESET_VALUE (1'b0)
  )
  u_link
  (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_live     (i_link_ok),
    .i_rd_clear (rd_status),
    .o_value    (link_view)
  );

  pms_latch_bit
  #(
    .EVENT_LEVEL (1'b1),
    .RESET_VALUE (1'b0)
  )
  u_jabber
  (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_live     (i_jabber),
    .i_rd_clear (rd_status),
    .o_value    (jabber_view)
  );

  // --------------------------------------------------------------------------
  // status word
  // --------------------------------------------------------------------------
  reg [15:0] status_word;

  always @*
  begin
    status_word = 16'h0000;
    status_word[`PMS_STAT_ABILITY_HI:`PMS_STAT_ABILITY_LO] = `PMS_STAT_ABILITY_VAL;
    status_word[`PMS_STAT_PREAMBLE_SUP] = 1'b0;
    status_word[`PMS_STAT_AN_DONE]      = an_done_q;
    status_word[`PMS_STAT_REMOTE_FLT]   = 1'b0;
    status_word[`PMS_STAT_AN_ABLE]      = 1'b1;
    status_word[`PMS_STAT_LINK]         = link_view;
    status_word[`PMS_STAT_JABBER]       = jabber_view;
    status_word[`PMS_STAT_EXT_CAP]      = 1'b1;
  end

  // --------------------------------------------------------------------------
  // advertisement register
  // --------------------------------------------------------------------------
  reg       adv_rf_q;
  reg [7:0] adv_tech_q;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      adv_rf_q   <= 1'b0;
      adv_tech_q <= `PMS_ADV_TECH_RST;
    end
    else if (wr_adv)
    begin
      adv_rf_q   <= i_reg_wdata[`PMS_ADV_REMOTE_FLT];
      adv_tech_q <= i_reg_wdata[`PMS_ADV_TECH_HI:`PMS_ADV_TECH_LO];
    end
  end

  // next page and reserved read zero; selector is not writable
  wire [15:0] adv_word;
  assign adv_word = {1'b0, 1'b0, adv_rf_q, adv_tech_q, `PMS_ADV_SEL_VAL};

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  reg [15:0] rdata_q;
  reg        rvalid_q;
  reg [15:0] rdata_d;

  always @*
  begin
    case (i_reg_addr)
      `PMS_OFF_CTRL:   rdata_d = ctrl_word;
      `PMS_OFF_STATUS: rdata_d = status_word;
      `PMS_OFF_ID_HI:  rdata_d = PHY_ID_HI;
      `PMS_OFF_ID_LO:  rdata_d = PHY_ID_LO;
      `PMS_OFF_ADV:    rdata_d = adv_word;
      default:         rdata_d = 16'h0000;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= i_reg_rd;
      if (i_reg_rd)
        rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // --------------------------------------------------------------------------
  // effective mode and line-side outputs
  // --------------------------------------------------------------------------
  reg speed_eff_q;
  reg duplex_eff_q;
  reg col_q;
  reg [15:0] adv_out_q;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      speed_eff_q  <= 1'b0;
      duplex_eff_q <= 1'b0;
      col_q        <= 1'b0;
      adv_out_q    <= 16'h0000;
    end
    else
    begin
      adv_out_q <= adv_word;
      // forced speed only counts while negotiation is off
      speed_eff_q <= an_en_q ? i_an_speed_100 : speed_q;
      if (loopback_q)
        duplex_eff_q <= LOOPBACK_FULL;
      else if (an_en_q)
        duplex_eff_q <= i_an_full_duplex;
      else
        duplex_eff_q <= duplex_view;
      // in loopback the line collision input is isolated
      col_q <= (col_test_q & i_tx_en) | (~loopback_q & i_line_col);
    end
  end

  assign o_an_enable   = an_en_q;
  assign o_an_restart  = restart_q;
  assign o_adv_word    = adv_out_q;
  assign o_speed_100   = speed_eff_q;
  assign o_full_duplex = duplex_eff_q;
  assign o_loopback    = loopback_q;
  assign o_rx_isolate  = loopback_q;
  assign o_power_down  = pwr_down_q;
  assign o_col         = col_q;

endmodule

// ---- verilog/pms_consts.vh ----
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

// ----------------------------------------------------------------------------
// register addresses on the management interface
// ----------------------------------------------------------------------------
`define PMS_ADDR_W            5
`define PMS_DATA_W            16
`define PMS_OFF_CTRL          5'h00
`define PMS_OFF_STATUS        5'h01
`define PMS_OFF_ID_HI         5'h02
`define PMS_OFF_ID_LO         5'h03
`define PMS_OFF_ADV           5'h04

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define PMS_CTRL_LOOPBACK     14
`define PMS_CTRL_SPEED        13
`define PMS_CTRL_AN_EN        12
`define PMS_CTRL_PWR_DOWN     11
`define PMS_CTRL_RSVD10       10
`define PMS_CTRL_AN_RESTART   9
`define PMS_CTRL_DUPLEX       8
`define PMS_CTRL_COL_TEST     7
`define PMS_CTRL_RSVD_HI      6
`define PMS_CTRL_RSVD_LO      0
`define PMS_CTRL_RSVD_RST     7'h00
`define PMS_CTRL_SPEED_RST    1'b1
`define PMS_CTRL_AN_EN_RST    1'b1

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define PMS_STAT_ABILITY_HI   14
`define PMS_STAT_ABILITY_LO   11
`define PMS_STAT_ABILITY_VAL  4'hf
`define PMS_STAT_RSVD_HI      10
`define PMS_STAT_RSVD_LO      7
`define PMS_STAT_PREAMBLE_SUP 6
`define PMS_STAT_AN_DONE      5
`define PMS_STAT_REMOTE_FLT   4
`define PMS_STAT_AN_ABLE      3
`define PMS_STAT_LINK         2
`define PMS_STAT_JABBER       1
`define PMS_STAT_EXT_CAP      0

// ----------------------------------------------------------------------------
// advertisement register fields
// ----------------------------------------------------------------------------
`define PMS_ADV_NEXT_PAGE     15
`define PMS_ADV_RSVD14        14
`define PMS_ADV_REMOTE_FLT    13
`define PMS_ADV_TECH_HI       12
`define PMS_ADV_TECH_LO       5
`define PMS_ADV_TECH_RST      8'h2f
`define PMS_ADV_SEL_HI        4
`define PMS_ADV_SEL_LO        0
`define PMS_ADV_SEL_VAL       5'h01

`endif

// ---- verilog/pms_latch_bit.v ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// latching status bit: holds the event level until the owning register is read
// ----------------------------------------------------------------------------
module pms_latch_bit
#(
  parameter EVENT_LEVEL = 1'b1,
  parameter RESET_VALUE = 1'b0
)
(
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_live,
  input  wire i_rd_clear,
  output wire o_value
);

  reg latched_q;

  // a read reloads the live level, so an event in the read cycle survives
  always @(posedge i_clk)
  begin
    if (i_rst)
      latched_q <= RESET_VALUE;
    else if (i_rd_clear)
      latched_q <= i_live;
    else if (i_live == EVENT_LEVEL)
      latched_q <= EVENT_LEVEL;
  end

  assign o_value = latched_q;

endmodule

// ---- tb/pms_regs_chk.sv ----
`timescale 1ns/100ps

module pms_regs_chk
(
  input wire        i_clk,
  input wire        i_rst,
  input wire [4:0]  i_reg_addr,
  input wire        i_reg_wr,
  input wire [15:0] i_reg_wdata,
  input wire        i_reg_rd,
  input wire        o_reg_rvalid,
  input wire        i_an_restart_ack,
  input wire        i_tx_en,
  input wire        i_line_col,
  input wire        o_an_restart,
  input wire [15:0] o_adv_word,
  input wire        o_full_duplex,
  input wire        o_loopback,
  input wire        o_rx_isolate,
  input wire        o_col
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------------------
  // restart handshake steps
  // --------------------------------------------------------------------------
  sequence s_restart_wr;
    i_reg_wr && i_reg_addr == 5'h00 && i_reg_wdata[9];
  endsequence
  sequence s_restart_acked;
    o_an_restart && i_an_restart_ack && !(i_reg_wr && i_reg_addr == 5'h00 && i_reg_wdata[9]);
  endsequence

  a_read_answer: assert property (o_reg_rvalid == $past(i_reg_rd))
    else $error("read valid not one cycle after read strobe");
  a_restart_set: assert property (s_restart_wr |=> o_an_restart)
    else $error("restart write did not raise restart");
  a_restart_clear: assert property (s_restart_acked |=> !o_an_restart)
    else $error("restart did not self clear after acceptance");
  a_restart_hold: assert property (o_an_restart && !i_an_restart_ack |=> o_an_restart)
    else $error("restart dropped before acceptance");
  a_col_quiet: assert property (!i_tx_en && !i_line_col |=> !o_col)
    else $error("collision without transmit enable");
  a_col_line: assert property (i_line_col && !o_loopback |=> o_col)
    else $error("line collision not passed on");
  a_loop_isolate: assert property (o_rx_isolate == o_loopback)
    else $error("receive isolation differs from loopback");
  a_loop_duplex: assert property (o_loopback && $past(o_loopback) |-> o_full_duplex)
    else $error("duplex bit affects loopback");
  a_adv_fixed: assert property (!$past(i_rst) |-> o_adv_word[15:14] == 2'b00 &&
                                o_adv_word[4:0] == 5'h01)
    else $error("advertisement fixed fields wrong");
endmodule

bind pms_regs pms_regs_chk i_pms_regs_chk (.*);

// ---- tb/pms_an_model.sv ----
`timescale 1ns/100ps

// negotiation engine stand-in: accepts a restart after ACK_DLY cycles and
// reports completion DONE_DLY cycles later; a slow ACK_DLY checks the pending bit
module pms_an_model
#(
  parameter ACK_DLY  = 8,
  parameter DONE_DLY = 4
)
(
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_restart,
  output reg  o_ack,
  output reg  o_complete
);
  reg [3:0] cnt_q;
  reg       busy_q;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_q      <= 4'h0;
      busy_q     <= 1'b0;
      o_ack      <= 1'b0;
      o_complete <= 1'b0;
    end
    else if (i_restart)
    begin
      o_complete <= 1'b0;
      busy_q     <= 1'b1;
      o_ack      <= (cnt_q == ACK_DLY);
      cnt_q      <= (cnt_q == ACK_DLY) ? 4'h0 : cnt_q + 4'h1;
    end
    else if (busy_q)
    begin
      o_ack <= 1'b0;
      // count restarts from zero so every restart made after a completion sees the same acceptance delay
      cnt_q <= (cnt_q == DONE_DLY) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == DONE_DLY)
      begin
        o_complete <= 1'b1;
        busy_q     <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/pms_regs_test.sv ----
`timescale 1ns/100ps

module pms_regs_test;
  reg         i_clk;
  reg         i_rst, rd, wr, ln, jb, tx, lc, spd, fdx;
  reg  [4:0]  addr;
  reg  [15:0] wdata;
  wire [15:0] rdata, adv;
  wire        rvalid, ack, cmpl, an_en, rs, s100, fd, lb, iso, pd, col;
  wire [15:0] rdata2;
  wire        fd2;
  integer     miscompares = 0;
  integer     n_checks = 0;

  pms_regs i_pms_regs (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_an_restart_ack(ack), .i_an_complete(cmpl), .i_an_speed_100(spd),
    .i_an_full_duplex(fdx), .i_link_ok(ln), .i_jabber(jb), .i_tx_en(tx), .i_line_col(lc),
    .o_an_enable(an_en), .o_an_restart(rs), .o_adv_word(adv), .o_speed_100(s100),
    .o_full_duplex(fd), .o_loopback(lb), .o_rx_isolate(iso), .o_power_down(pd), .o_col(col));

  // second copy built for a line side with only full duplex
  pms_regs #(.SINGLE_DUPLEX(1'b1), .SINGLE_DUP_FULL(1'b1)) i_pms_regs_single (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata2), .o_reg_rvalid(),
    .i_an_restart_ack(ack), .i_an_complete(cmpl), .i_an_speed_100(spd),
    .i_an_full_duplex(fdx), .i_link_ok(ln), .i_jabber(jb), .i_tx_en(tx), .i_line_col(lc),
    .o_an_enable(), .o_an_restart(), .o_adv_word(), .o_speed_100(),
    .o_full_duplex(fd2), .o_loopback(), .o_rx_isolate(), .o_power_down(), .o_col());

  pms_an_model #(.ACK_DLY(8), .DONE_DLY(4)) i_pms_an_model (.i_clk(i_clk), .i_rst(i_rst),
    .i_restart(rs), .o_ack(ack), .o_complete(cmpl));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // --------------------------------------------------------------------------
  // access and compare tasks
  // --------------------------------------------------------------------------
  task give_verdict;
    begin
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task chk(input [8*8:1] nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wreg(input [4:0] a, input [15:0] v);
    begin
      @(posedge i_clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge i_clk);
      wr    <= 1'b0;
    end
  endtask

  // read data and valid are registered, so they are looked at just after the answer edge
  task rchk(input [4:0] a, input [15:0] e);
    begin
      @(posedge i_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge i_clk);
      rd   <= 1'b0;
      #1;
      chk("rvalid", 16'h0001, {15'h0000, rvalid});
      chk("rdata", e, rdata);
    end
  endtask

  task sett;
    begin
      repeat (3) @(posedge i_clk);
      #1;
    end
  endtask

  task done(input [8*8:1] nm);
    $display("test %0s finished", nm);
  endtask

  initial
  begin
    repeat (2000) @(posedge i_clk);
    miscompares = miscompares + 1;
    give_verdict;
  end

  // --------------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    {i_rst, rd, wr, ln, jb, tx, lc, spd, fdx} = 9'h100;
    addr  = 5'h00;
    wdata = 16'h0000;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rchk(5'h00, 16'h3000);
    rchk(5'h01, 16'h7809);
    rchk(5'h02, 16'h1234);
    rchk(5'h03, 16'h5678);
    rchk(5'h04, 16'h05e1);
    rchk(5'h1f, 16'h0000);
    wreg(5'h02, 16'hffff);
    rchk(5'h02, 16'h1234);
    wreg(5'h04, 16'hffff);
    rchk(5'h04, 16'h3fe1);
    wreg(5'h04, 16'h0000);
    rchk(5'h04, 16'h0001);
    done("regs");
    @(posedge i_clk);
    ln <= 1'b1;
    rchk(5'h01, 16'h7809);
    rchk(5'h01, 16'h780d);
    @(posedge i_clk);
    ln <= 1'b0;
    @(posedge i_clk);
    ln <= 1'b1;
    jb <= 1'b1;
    @(posedge i_clk);
    jb <= 1'b0;
    rchk(5'h01, 16'h780b);
    rchk(5'h01, 16'h780d);
    done("latch");
    wreg(5'h00, 16'h1200);
    rchk(5'h00, 16'h1200);
    repeat (30) @(posedge i_clk);
    rchk(5'h00, 16'h1000);
    rchk(5'h01, 16'h782d);
    wreg(5'h00, 16'h1200);
    rchk(5'h01, 16'h780d);
    repeat (30) @(posedge i_clk);
    rchk(5'h01, 16'h782d);
    done("restart");
    wreg(5'h00, 16'h0080);
    tx <= 1'b1;
    sett;
    chk("col", 16'h0001, {15'h0000, col});
    wreg(5'h00, 16'h0000);
    sett;
    chk("col", 16'h0000, {15'h0000, col});
    @(posedge i_clk);
    lc <= 1'b1;
    sett;
    chk("col", 16'h0001, {15'h0000, col});
    wreg(5'h00, 16'h4000);
    sett;
    chk("col", 16'h0000, {15'h0000, col});
    chk("isolate", 16'h0001, {15'h0000, iso});
    chk("duplex", 16'h0001, {15'h0000, fd});
    @(posedge i_clk);
    {lc, tx, spd} <= 3'b001;
    wreg(5'h00, 16'h0100);
    sett;
    chk("duplex", 16'h0001, {15'h0000, fd});
    wreg(5'h00, 16'h0000);
    sett;
    chk("duplex", 16'h0000, {15'h0000, fd});
    wreg(5'h00, 16'h1100);
    sett;
    chk("duplex", 16'h0000, {15'h0000, fd});
    chk("speed", 16'h0001, {15'h0000, s100});
    chk("an_en", 16'h0001, {15'h0000, an_en});
    chk("adv", 16'h0001, adv);
    wreg(5'h00, 16'h2c00);
    rchk(5'h00, 16'h2c00);
    chk("pwrdown", 16'h0001, {15'h0000, pd});
    chk("an_en", 16'h0000, {15'h0000, an_en});
    chk("sd ctrl", 16'h2d00, rdata2);
    chk("sd dupl", 16'h0001, {15'h0000, fd2});
    done("line");
    give_verdict;
  end
endmodule
